// ==== inc/sfr_regs.vh ====
// Purpose: constants for the serial flash read path
// Assumes: plain verilog-2005, included by bare name
// Notes:   register offsets are byte addresses on avalon-mm
//
// Contract
// [RULE1] basic read: 03h, then 24-bit address msb-first
// [RULE2] sample on rising sclk, drive on falling
// [RULE3] address increments after every output byte
// [RULE4] select high ends read, outputs released
// [RULE5] basic read ignored while write in progress
// [RULE6] basic read only in single-line command mode
// [RULE7] fast read: eight dummy clocks, input ignored
// [RULE8] 3Bh: eight dummies, two bits per clock
// [RULE9] host releases lines before first data fall
// [RULE10] 6Bh: four bits per clock, needs quad_enable
// [RULE11] BBh: address and mode two bits per clock
// [RULE12] mode bits 5:4 = 10 skips next opcode
// [RULE13] other mode values leave continuous read mode
// [RULE14] low mode nibble is ignored
// [RULE15] host sends all ones to exit continuous mode
// [RULE16] EBh: four bits per clock, four dummies
// [RULE17] quad i/o read needs quad_enable
// [RULE18] wrap within aligned section of the page
// [RULE19] three-bit wrap setting held by the device
// [RULE20] disable bit 0 wraps; 8/16/32/64; resets to 1
// [RULE21] 77h: 24 dummy bits then eight wrap bits
// [RULE22] read address rolls over to zero at top
`ifndef SFR_REGS_VH
`define SFR_REGS_VH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define SFR_OP_READ      8'h03
`define SFR_OP_FAST      8'h0b
`define SFR_OP_DUAL_OUT  8'h3b
`define SFR_OP_QUAD_OUT  8'h6b
`define SFR_OP_DUAL_IO   8'hbb
`define SFR_OP_QUAD_IO   8'heb
`define SFR_OP_SET_WRAP  8'h77

// ----------------------------------------------------------------
// frame lengths in bits or clocks, continuous mode code, wrap reset value
// ----------------------------------------------------------------
`define SFR_CMD_BITS     6'h08
`define SFR_ADDR_BITS    6'h18
`define SFR_MODE_BITS    6'h08
`define SFR_WRAP_BITS    6'h20
`define SFR_FAST_DUMMY   4'h8
`define SFR_QIO_DUMMY    4'h4
`define SFR_CONT_CODE    2'h2
`define SFR_WRAP_RST     3'h1

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SFR_REG_CTRL     4'h0
`define SFR_REG_STATUS   4'h4
`define SFR_REG_MADDR    4'h8
`define SFR_REG_MDATA    4'hc
`define SFR_CTRL_QUAD_EN 0
`define SFR_CTRL_BUSY    1
`define SFR_MEM_DEPTH    256

`endif

// ==== logic/sfr_read_path.v ====
// Purpose: read command engine of a serial nor flash slave
// Assumes: sclk and select are far slower than i_clk (8x or more)
// Notes:   array holds one 256-byte page, mirrored over 24-bit space
`timescale 1ns/1ps
`include "sfr_regs.vh"

module sfr_read_path
(
	input  wire        i_clk,
	input  wire        i_rst_b,
	input  wire [3:0]  i_avs_address,
	input  wire        i_avs_read,
	input  wire        i_avs_write,
	input  wire [31:0] i_avs_writedata,
	input  wire [3:0]  i_avs_byteenable,
	output reg  [31:0] o_avs_readdata,
	output wire        o_avs_waitrequest,
	input  wire        i_sclk,
	input  wire        i_cs_b,
	input  wire [3:0]  i_io,
	output reg  [3:0]  o_io,
	output reg  [3:0]  o_io_oe_b
);

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam ST_IDLE  = 3'h0;
	localparam ST_CMD   = 3'h1;
	localparam ST_ADDR  = 3'h2;
	localparam ST_MODE  = 3'h3;
	localparam ST_DUMMY = 3'h4;
	localparam ST_DATA  = 3'h5;
	localparam ST_WRAP  = 3'h6;
	localparam ST_SKIP  = 3'h7;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	reg  [7:0]  mem [0:`SFR_MEM_DEPTH-1];
	reg  [2:0]  sclk_sync_q;
	reg  [1:0]  cs_sync_q;
	reg  [3:0]  io_s1_q;
	reg  [3:0]  io_s2_q;
	reg  [2:0]  st_q;
	reg  [2:0]  lanes_q;
	reg  [2:0]  olanes_q;
	reg  [7:0]  cmd_q;
	reg  [5:0]  cnt_q;
	reg  [3:0]  dummy_q;
	reg         has_mode_q;
	reg  [31:0] sh_q;
	reg  [23:0] addr_q;
	reg  [7:0]  byte_q;
	reg  [2:0]  pos_q;
	reg         cont_q;
	reg  [7:0]  cont_cmd_q;
	reg  [2:0]  wrap_q;
	reg         quad_en_q;
	reg         wr_busy_q;
	reg  [7:0]  maddr_q;
	reg         ack_q;
	reg  [31:0] sh_d;
	reg  [3:0]  out_d;
	reg  [3:0]  oe_b_d;
	reg  [5:0]  wmask;
	reg  [23:0] next_addr;
	wire        rise;
	wire        fall;
	wire        cs_low;
	wire        req;
	wire [5:0]  cnt_n;
	wire [3:0]  pos_n;
	wire [7:0]  shifted;

	// ----------------------------------------------------------------
	// pin synchronisers and edge detect
	// ----------------------------------------------------------------
	always @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			sclk_sync_q <= 3'h0;
			cs_sync_q   <= 2'h3;
			io_s1_q     <= 4'h0;
			io_s2_q     <= 4'h0;
		end
		else
		begin
			sclk_sync_q <= {sclk_sync_q[1:0], i_sclk};
			cs_sync_q   <= {cs_sync_q[0], i_cs_b};
			io_s1_q     <= i_io;
			io_s2_q     <= io_s1_q;
		end
	end

	// edges are seen on stages two and three only
	assign rise   = sclk_sync_q[1] & ~sclk_sync_q[2];
	assign fall   = ~sclk_sync_q[1] & sclk_sync_q[2];
	assign cs_low = ~cs_sync_q[1];

	// ----------------------------------------------------------------
	// input shifting
	// ----------------------------------------------------------------
	assign cnt_n = cnt_q + {3'h0, lanes_q};

	always @*
	begin
		case (lanes_q)
			3'h2:    sh_d = {sh_q[29:0], io_s2_q[1:0]};
			3'h4:    sh_d = {sh_q[27:0], io_s2_q};
			default: sh_d = {sh_q[30:0], io_s2_q[0]}; // RULE1
		endcase
	end

	// ----------------------------------------------------------------
	// output lanes and address step
	// ----------------------------------------------------------------
	assign shifted = byte_q << pos_q;
	assign pos_n   = {1'b0, pos_q} + {1'b0, olanes_q};

	always @*
	begin
		case (olanes_q)
			3'h2:
			begin
				out_d  = {2'h0, shifted[7:6]}; // RULE8
				oe_b_d = 4'hc;
			end
			3'h4:
			begin
				out_d  = shifted[7:4]; // RULE10
				oe_b_d = 4'h0;
			end
			default:
			begin
				out_d  = {2'h0, shifted[7], 1'b0}; // RULE2
				oe_b_d = 4'hd;
			end
		endcase
	end

	always @*
	begin
		case (wrap_q[2:1])
			2'h0:    wmask = 6'h07;
			2'h1:    wmask = 6'h0f;
			2'h2:    wmask = 6'h1f;
			default: wmask = 6'h3f; // RULE20
		endcase
		if (!wrap_q[0] && cmd_q == `SFR_OP_QUAD_IO)
			next_addr = {addr_q[23:6], // RULE18
				(addr_q[5:0] & ~wmask) |
				((addr_q[5:0] + 6'h01) & wmask)};
		else
			next_addr = addr_q + 24'h000001; // RULE22
	end

	// ----------------------------------------------------------------
	// link state machine
	// ----------------------------------------------------------------
	always @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			st_q       <= ST_IDLE;
			lanes_q    <= 3'h1;
			olanes_q   <= 3'h1;
			cmd_q      <= 8'h00;
			cnt_q      <= 6'h00;
			dummy_q    <= 4'h0;
			has_mode_q <= 1'b0;
			sh_q       <= 32'h0;
			addr_q     <= 24'h0;
			byte_q     <= 8'h00;
			pos_q      <= 3'h0;
			cont_q     <= 1'b0;
			cont_cmd_q <= 8'h00;
			wrap_q     <= `SFR_WRAP_RST; // RULE20
			o_io       <= 4'h0;
			o_io_oe_b  <= 4'hf;
		end
		else if (!cs_low)
		begin
			// select high ends any frame, lines let go at once
			st_q      <= ST_IDLE; // RULE4
			o_io_oe_b <= 4'hf;
			o_io      <= 4'h0;
		end
		else
		begin
			case (st_q)
				ST_IDLE:
				begin
					cnt_q <= 6'h00;
					if (cont_q)
					begin
						// opcode omitted, address follows at once
						st_q    <= ST_ADDR; // RULE12
						cmd_q   <= cont_cmd_q;
						lanes_q <= (cont_cmd_q == `SFR_OP_QUAD_IO) ?
							3'h4 : 3'h2;
					end
					else
					begin
						st_q    <= ST_CMD; // RULE6
						lanes_q <= 3'h1;
					end
				end
				ST_CMD:
				begin
					if (rise)
					begin
						sh_q  <= sh_d;
						cnt_q <= cnt_n;
						if (cnt_n == `SFR_CMD_BITS)
						begin
							cnt_q      <= 6'h00;
							cmd_q      <= sh_d[7:0];
							st_q       <= ST_ADDR;
							has_mode_q <= 1'b0;
							dummy_q    <= 4'h0;
							case (sh_d[7:0])
								`SFR_OP_READ:
								begin
									olanes_q <= 3'h1;
									if (wr_busy_q)
										st_q <= ST_SKIP; // RULE5
								end
								`SFR_OP_FAST:
								begin
									olanes_q <= 3'h1;
									dummy_q  <= `SFR_FAST_DUMMY; // RULE7
								end
								`SFR_OP_DUAL_OUT:
								begin
									olanes_q <= 3'h2;
									dummy_q  <= `SFR_FAST_DUMMY; // RULE8
								end
								`SFR_OP_QUAD_OUT:
								begin
									olanes_q <= 3'h4;
									dummy_q  <= `SFR_FAST_DUMMY;
									if (!quad_en_q)
										st_q <= ST_SKIP; // RULE10
								end
								`SFR_OP_DUAL_IO:
								begin
									lanes_q    <= 3'h2; // RULE11
									olanes_q   <= 3'h2;
									has_mode_q <= 1'b1;
								end
								`SFR_OP_QUAD_IO:
								begin
									lanes_q    <= 3'h4; // RULE16
									olanes_q   <= 3'h4;
									has_mode_q <= 1'b1;
									if (!quad_en_q)
										st_q <= ST_SKIP; // RULE17
								end
								`SFR_OP_SET_WRAP:
								begin
									lanes_q <= 3'h4;
									st_q    <= ST_WRAP; // RULE21
								end
								default: st_q <= ST_SKIP;
							endcase
						end
					end
				end
				ST_ADDR:
				begin
					if (rise)
					begin
						sh_q  <= sh_d;
						cnt_q <= cnt_n;
						if (cnt_n == `SFR_ADDR_BITS)
						begin
							cnt_q  <= 6'h00;
							addr_q <= sh_d[23:0]; // RULE1
							if (has_mode_q)
								st_q <= ST_MODE;
							else if (dummy_q != 4'h0)
								st_q <= ST_DUMMY;
							else
							begin
								st_q   <= ST_DATA;
								byte_q <= mem[sh_d[7:0]];
								pos_q  <= 3'h0;
							end
						end
					end
				end
				ST_MODE:
				begin
					if (rise)
					begin
						sh_q  <= sh_d;
						cnt_q <= cnt_n;
						if (cnt_n == `SFR_MODE_BITS)
						begin
							cnt_q      <= 6'h00;
							// low nibble plays no part
							cont_q     <= (sh_d[5:4] == `SFR_CONT_CODE); // RULE14
							cont_cmd_q <= cmd_q; // RULE13
							if (cmd_q == `SFR_OP_QUAD_IO)
							begin
								dummy_q <= `SFR_QIO_DUMMY; // RULE16
								st_q    <= ST_DUMMY;
							end
							else
							begin
								st_q   <= ST_DATA; // RULE11
								byte_q <= mem[addr_q[7:0]];
								pos_q  <= 3'h0;
							end
						end
					end
				end
				ST_DUMMY:
				begin
					// line contents are not looked at here
					if (rise)
					begin
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q + 6'h01 == {2'h0, dummy_q}) // RULE7
						begin
							cnt_q  <= 6'h00;
							st_q   <= ST_DATA;
							byte_q <= mem[addr_q[7:0]];
							pos_q  <= 3'h0;
						end
					end
				end
				ST_DATA:
				begin
					if (fall)
					begin
						o_io      <= out_d; // RULE2
						o_io_oe_b <= oe_b_d; // RULE9
						pos_q     <= pos_n[2:0];
						if (pos_n[3])
						begin
							addr_q <= next_addr; // RULE3
							byte_q <= mem[next_addr[7:0]];
						end
					end
				end
				ST_WRAP:
				begin
					if (rise)
					begin
						sh_q  <= sh_d;
						cnt_q <= cnt_n;
						if (cnt_n == `SFR_WRAP_BITS)
						begin
							wrap_q <= sh_d[6:4]; // RULE19
							st_q   <= ST_SKIP;
						end
					end
				end
				default:
				begin
					// ignored command: wait quietly for select high
					st_q <= ST_SKIP;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// avalon-mm slave, one wait state on every access
	// ----------------------------------------------------------------
	assign req               = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = req & ~ack_q;

	always @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			ack_q          <= 1'b0;
			o_avs_readdata <= 32'h0;
			quad_en_q      <= 1'b0;
			wr_busy_q      <= 1'b0;
			maddr_q        <= 8'h00;
		end
		else
		begin
			ack_q <= req & ~ack_q;
			if (req && !ack_q)
			begin
				case (i_avs_address)
					`SFR_REG_CTRL:
						o_avs_readdata <= {30'h0, wr_busy_q, quad_en_q};
					`SFR_REG_STATUS:
						o_avs_readdata <= {24'h0, cs_low, st_q,
							wrap_q, cont_q};
					`SFR_REG_MADDR:
						o_avs_readdata <= {24'h0, maddr_q};
					`SFR_REG_MDATA:
						o_avs_readdata <= {24'h0, mem[maddr_q]};
					default:
						o_avs_readdata <= 32'h0;
				endcase
			end
			// write lands on the edge that completes the handshake
			if (i_avs_write && ack_q && i_avs_byteenable[0])
			begin
				case (i_avs_address)
					`SFR_REG_CTRL:
					begin
						quad_en_q <= i_avs_writedata[`SFR_CTRL_QUAD_EN];
						wr_busy_q <= i_avs_writedata[`SFR_CTRL_BUSY];
					end
					`SFR_REG_MADDR:
						maddr_q <= i_avs_writedata[7:0];
					`SFR_REG_MDATA:
						maddr_q <= maddr_q + 8'h01;
					default:
						maddr_q <= maddr_q;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// page array, loaded by software, no reset so it maps to ram
	// ----------------------------------------------------------------
	always @(posedge i_clk)
	begin
		if (i_avs_write && ack_q && i_avs_byteenable[0] &&
			i_avs_address == `SFR_REG_MDATA)
			mem[maddr_q] <= i_avs_writedata[7:0];
	end

endmodule

// ==== tb/sfr_read_path_properties.sv ====
// Purpose: port checks of the read path
// Assumes: one clock, sync low reset
// Notes:   link timing assumes 8 clocks per sclk
`timescale 1ns/1ps
module sfr_chk
(
	input wire        i_clk,
	input wire        i_rst_b,
	input wire [3:0]  i_avs_address,
	input wire        i_avs_read,
	input wire        i_avs_write,
	input wire [31:0] o_avs_readdata,
	input wire        o_avs_waitrequest,
	input wire        i_sclk,
	input wire        i_cs_b,
	input wire [3:0]  o_io,
	input wire [3:0]  o_io_oe_b
);
	// ------
	// checks
	// ------
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	wire req = i_avs_read | i_avs_write;
	wire rdok = i_avs_read & ~o_avs_waitrequest;
	sequence s_wait;
		req && o_avs_waitrequest;
	endsequence
	sequence s_idle;
		i_cs_b [*6];
	endsequence
	chk_wait_one: assert property (s_wait |=> !o_avs_waitrequest)
		else $error("waitrequest held too long");
	chk_wait_first: assert property ($rose(req) |-> o_avs_waitrequest)
		else $error("no wait state");
	chk_rd_unmapped: assert property
		(rdok && i_avs_address[1:0] != 2'h0 |-> o_avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_ctrl_upper: assert property
		(rdok && i_avs_address == 4'h0 |-> o_avs_readdata[31:2] == 30'h0)
		else $error("control upper bits set");
	chk_stat_upper: assert property
		(rdok && i_avs_address == 4'h4 |-> o_avs_readdata[31:8] == 24'h0)
		else $error("status upper bits set");
	chk_oe_legal: assert property
		(o_io_oe_b inside {4'hf, 4'hd, 4'hc, 4'h0})
		else $error("bad enable pattern");
	chk_oe_release: assert property (s_idle |-> o_io_oe_b == 4'hf)
		else $error("drive after deselect");
	chk_oe_select: assert property (o_io_oe_b != 4'hf |-> !$past(i_cs_b, 6))
		else $error("drive without select");
	chk_out_steady: assert property
		(i_sclk && $past(i_sclk) && $past(i_sclk, 2) |-> $stable(o_io))
		else $error("output moved while sclk high");
endmodule
bind sfr_read_path sfr_chk u_chk (.i_clk, .i_rst_b, .i_avs_address,
	.i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest,
	.i_sclk, .i_cs_b, .o_io, .o_io_oe_b);

// ==== tb/sfr_host_model.sv ====
// Purpose: host controller model on the serial link
// Assumes: eight i_clk per sclk, sclk idle low
// Notes:   released lines toggle so no stale value passes
`timescale 1ns/1ps
module sfr_host
(
	input  wire        i_clk,
	input  wire  [3:0] i_io,
	input  wire  [3:0] i_oe_b,
	output logic       o_sclk,
	output logic       o_cs_b,
	output logic [3:0] o_line
);
	// ------
	// link driver
	// ------
	logic [3:0] hv_q   = 4'h0;
	logic [3:0] hoe_q  = 4'h0;
	logic [3:0] last_q = 4'h0;
	logic [7:0] rx [0:7];
	logic       drv_seen;
	initial o_sclk = 1'b0;
	initial o_cs_b = 1'b1;
	always_comb
		for (int k = 0; k < 4; k++)
			o_line[k] = hoe_q[k] ? hv_q[k] :
				(i_oe_b[k] ? ~last_q[k] : i_io[k]);
	always @(posedge i_clk)
		last_q <= o_line;
	// data set with the fall, read in mid high phase
	task automatic cyc(input [3:0] v, input [3:0] oe, output [3:0] r);
		hv_q <= v;
		hoe_q <= oe;
		repeat (4) @(posedge i_clk);
		o_sclk <= 1'b1;
		repeat (2) @(posedge i_clk);
		r = o_line;
		drv_seen |= (i_oe_b != 4'hf);
		repeat (2) @(posedge i_clk);
		o_sclk <= 1'b0;
	endtask
	task automatic shv(input [31:0] v, input int bits, input int ln);
		logic [3:0] r;
		logic [3:0] m;
		m = 4'((1 << ln) - 1);
		for (int i = bits / ln - 1; i >= 0; i--)
			cyc(4'(v >> (i * ln)) & m, m, r);
	endtask
	task automatic frame(input [7:0] op, input sk, input int al,
		input [31:0] am, input int ab, input int dm, input int dl,
		input int n);
		logic [3:0] r;
		drv_seen = 1'b0;
		@(posedge i_clk);
		o_cs_b <= 1'b0;
		if (!sk)
			shv({24'h0, op}, 8, 1);
		shv(am, ab, al);
		for (int i = 0; i < dm; i++)
			cyc({3'h0, i[0]}, (dl == 1) ? 4'h1 : 4'h0, r);
		for (int b = 0; b < n; b++)
			for (int i = 0; i < 8 / dl; i++)
			begin
				cyc(4'h0, (dl == 1) ? 4'h1 : 4'h0, r);
				rx[b] = 8'(rx[b] << dl) | 8'((dl == 1) ? {3'h0, r[1]} :
					r & 4'((1 << dl) - 1));
			end
		@(posedge i_clk);
		o_cs_b <= 1'b1;
		hoe_q <= 4'h0;
		repeat (8) @(posedge i_clk);
	endtask
endmodule

// ==== tb/sfr_read_path_tb_top.sv ====
// Purpose: self-checking bench of the read path
// Assumes: 10 MHz clock, sclk 800 ns from the host model
// Notes:   memory preloaded through the register bus
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
	num_errors++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module sfr_read_path_tb_top;
	// ------
	// harness
	// ------
	typedef struct packed {
		logic [7:0] op;
		logic [3:0] al;
		logic [3:0] dm;
		logic [3:0] dl;
		logic [2:0] qwo;
	} sfr_row_t;
	sfr_row_t rows [9] = '{
		'{8'h03, 4'h1, 4'h0, 4'h1, 3'h1}, '{8'h0b, 4'h1, 4'h8, 4'h1, 3'h1},
		'{8'h3b, 4'h1, 4'h8, 4'h2, 3'h1}, '{8'h6b, 4'h1, 4'h8, 4'h4, 3'h5},
		'{8'hbb, 4'h2, 4'h0, 4'h2, 3'h1}, '{8'heb, 4'h4, 4'h4, 4'h4, 3'h5},
		'{8'h03, 4'h1, 4'h0, 4'h1, 3'h2}, '{8'h6b, 4'h1, 4'h8, 4'h4, 3'h0},
		'{8'heb, 4'h4, 4'h4, 4'h4, 3'h0}};
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [3:0]  ad = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0]  be = 4'hf;
	wire  [31:0] rdata;
	wire         wreq;
	wire         sclk;
	wire         cs_b;
	wire  [3:0]  line;
	wire  [3:0]  dout;
	wire  [3:0]  oe_b;
	logic [31:0] q;
	logic [23:0] a;
	int          num_errors = 0;
	int          num_checks = 0;
	int          cyc_n = 0;
	int          ln;
	sfr_read_path DUT (.i_clk(clk), .i_rst_b(rst_b), .i_avs_address(ad),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.i_avs_byteenable(be), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .i_sclk(sclk), .i_cs_b(cs_b),
		.i_io(line), .o_io(dout), .o_io_oe_b(oe_b));
	sfr_host u_host (.i_clk(clk), .i_io(dout), .i_oe_b(oe_b),
		.o_sclk(sclk), .o_cs_b(cs_b), .o_line(line));
	initial
		forever #50 clk = ~clk;
	function automatic [7:0] mv(input [23:0] x);
		return 8'(x[7:0] * 8'h1d + 8'h07);
	endfunction
	task automatic av(input w, input [3:0] x, input [31:0] d);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		ad <= x;
		wd <= d;
		// waitrequest is judged on the rising edge, as the slave sees it
		do
			@(posedge clk);
		while (wreq);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc_n++;
		if (cyc_n == 40000)
		begin
			num_errors++;
			end_sim;
		end
	end
	// ------
	// sequence
	// ------
	initial
	begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		av(0, 4'h0, 0);
		`CHK("ctrl", 32'h0, q);
		av(0, 4'h4, 0);
		`CHK("status", 5'h02, {q[7], q[3:0]});
		av(0, 4'h2, 0);
		`CHK("unmapped", 32'h0, q);
		be <= 4'he;
		av(1, 4'h0, 32'h3);
		be <= 4'hf;
		av(0, 4'h0, 0);
		`CHK("be ignored", 32'h0, q);
		av(1, 4'h8, 0);
		for (int i = 0; i < 256; i++)
			av(1, 4'hc, {24'h0, mv(24'(i))});
		av(0, 4'h8, 0);
		`CHK("page index", 32'h0, q);
		av(0, 4'hc, 0);
		`CHK("page data", {24'h0, mv(24'h0)}, q);
		for (int i = 0; i < 9; i++)
		begin
			a = 24'h20 + 24'(i * 11);
			ln = int'(rows[i].al);
			av(1, 4'h0, {30'h0, rows[i].qwo[1:0]});
			u_host.frame(rows[i].op, 0, ln, ln > 1 ? {a, 8'h00} : {8'h0, a},
				ln > 1 ? 32 : 24, int'(rows[i].dm), int'(rows[i].dl), 3);
			`CHK("drive", rows[i].qwo[0], u_host.drv_seen);
			for (int k = 0; k < 3 && rows[i].qwo[0]; k++)
				`CHK("data", mv(a + 24'(k)), u_host.rx[k]);
		end
		u_host.frame(8'h03, 0, 1, 32'hfffffe, 24, 0, 1, 3);
		for (int k = 0; k < 3; k++)
			`CHK("roll", mv(24'hfffffe + 24'(k)), u_host.rx[k]);
		av(1, 4'h0, 32'h1);
		for (int j = 0; j < 2; j++)
		begin
			ln = j ? 4 : 2;
			u_host.frame(j ? 8'heb : 8'hbb, 0, ln, 32'h802c, 32,
				j ? 4 : 0, ln, 2);
			`CHK("cont first", mv(24'h81), u_host.rx[1]);
			av(0, 4'h4, 0);
			`CHK("cont on", 1'b1, q[0]);
			// line 0 stays high through address and mode to force the exit
			a = j ? 24'h111111 : 24'h555555;
			u_host.frame(8'h00, 1, ln, {a, a[7:0]}, 32, j ? 4 : 0, ln, 2);
			`CHK("cont data", mv(a + 24'h1), u_host.rx[1]);
			av(0, 4'h4, 0);
			`CHK("cont off", 1'b0, q[0]);
		end
		for (int w = 0; w < 4; w++)
		begin
			ln = 8 << w;
			u_host.frame(8'h77, 0, 4, {24'h0, 1'b0, 2'(w), 5'h0}, 32, 0, 4, 0);
			av(0, 4'h4, 0);
			`CHK("wrap set", 3'(w << 1), q[3:1]);
			u_host.frame(8'heb, 0, 4, {24'(64 + ln - 2), 8'h0}, 32, 4, 4, 4);
			for (int k = 0; k < 4; k++)
				`CHK("wrap", mv(24'(64 + (ln - 2 + k) % ln)), u_host.rx[k]);
		end
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		av(0, 4'h4, 0);
		`CHK("wrap reset", 3'h1, q[3:1]);
		av(1, 4'h0, 32'h1);
		u_host.frame(8'heb, 0, 4, 32'h4600, 32, 4, 4, 4);
		for (int k = 0; k < 4; k++)
			`CHK("linear", mv(24'h46 + 24'(k)), u_host.rx[k]);
		end_sim;
	end
endmodule
